// ===== fcpd_regs.vh
// Constants for the floppy command phase decoder
`ifndef FCPD_REGS_VH
`define FCPD_REGS_VH
`define FCPD_OP_DUMP 8'h0E
`define FCPD_OP_PERP 8'h12
`define FCPD_OP_RDID_LOW 5'h0A
`define FCPD_OP_LOCK_LOW 5'h14
`define FCPD_OP_RDID_MASK 8'hBF
`define FCPD_OP_LOCK_MASK 8'h7F
`define FCPD_OP_LOCK 8'h14
`define FCPD_OP_RDID 8'h0A
`define FCPD_XFER_READ 5'h06
`define FCPD_XFER_READ_DEL 5'h0C
`define FCPD_XFER_WRITE 5'h05
`define FCPD_XFER_WRITE_DEL 5'h09
`define FCPD_XFER_VERIFY 5'h16
`define FCPD_XFER_FORMAT 5'h0D
`define FCPD_ST0_INVALID 8'h80
`define FCPD_XFER_PARAMS 4'h8
`define FCPD_XFER_RESULTS 4'h7
`define FCPD_DUMP_RESULTS 4'hA
`define FCPD_LOCK_BIT 4
`endif

// ===== fcpd_result_mux.v
// Result byte selector for the floppy command phase decoder
`timescale 1ns/100ps
module fcpd_result_mux (
    input wire [3:0] idx,
    input wire [79:0] bytes,
    output reg [7:0] data
);
    always @*
    begin
        if (idx < 4'hA)
            data = bytes[idx*8 +: 8];
        else
            data = 8'h00;
    end
endmodule // fcpd_result_mux

// ===== fcpd_decoder.v
// Command and result phase decoder for a floppy controller
// Notes on behaviour
// - Dump returns sector count after format, else end
// - Perpendicular bits never drive drive select pins
// - Transfer commands share parameters, differ in bits 0-4
// - Implied seek precedes transfer when enabled
// - Drive busy set during implied seek
// - Failed seek ends command, reports status and cylinder
// - Opcode 12h takes one byte, no results
// - Unknown opcode gives single result byte 80h
// - Read identifier captures first good identifier
// - Read identifier returns seven result bytes
`timescale 1ns/100ps
`include "fcpd_regs.vh"
module fcpd_decoder (
    input wire clk,
    input wire rst_n,
    input wire cmd_wr,
    input wire [7:0] cmd_data,
    input wire res_rd,
    input wire [31:0] present_cylinder_number,
    input wire [3:0] step_rate_time,
    input wire [3:0] head_unload_time,
    input wire [6:0] head_load_time,
    input wire non_dma_flag,
    input wire implied_seek_enable,
    input wire fifo_disable_flag,
    input wire poll_disable,
    input wire [3:0] fifo_threshold,
    input wire [7:0] precomp_start_track,
    input wire seek_done,
    input wire seek_fail,
    input wire [7:0] seek_fail_st0,
    input wire [7:0] seek_fail_cyl,
    input wire id_found,
    input wire [31:0] id_field,
    input wire [23:0] op_status,
    input wire op_done,
    output reg [7:0] res_data_ff,
    output reg res_valid_ff,
    output reg cmd_busy_ff,
    output reg [3:0] drive_busy_ff,
    output reg seek_req_ff,
    output reg [7:0] seek_cyl_ff,
    output reg [1:0] seek_drive_ff,
    output reg id_req_ff,
    output reg xfer_req_ff,
    output reg [4:0] xfer_kind_ff,
    output reg [63:0] xfer_params_ff,
    output reg double_density_flag_ff,
    output reg head_select_ff,
    output reg [1:0] write_gate_mode_ff,
    output reg [3:0] perp_drive_ff,
    output reg lock_ff,
    output reg standby_ff
);
    localparam S_IDLE = 6'h01;
    localparam S_PARM = 6'h02;
    localparam S_SEEK = 6'h04;
    localparam S_EXEC = 6'h08;
    localparam S_RES = 6'h10;
    localparam S_RDID = 6'h20;
    reg [5:0] state_ff;
    reg [7:0] op_ff;
    reg [3:0] pcnt_ff;
    reg [3:0] need_ff;
    reg [3:0] ridx_ff;
    reg [3:0] rcnt_ff;
    reg [79:0] rbytes_ff;
    reg [7:0] eot_ff;
    reg [7:0] sc_ff;
    reg last_fmt_ff;
    wire [7:0] mux_out;
    wire [4:0] low = cmd_data[4:0];
    wire is_xfer = (low == `FCPD_XFER_READ) || (low == `FCPD_XFER_READ_DEL)
        || (low == `FCPD_XFER_WRITE) || (low == `FCPD_XFER_WRITE_DEL)
        || (low == `FCPD_XFER_VERIFY);
    wire is_fmt = (cmd_data == {2'b00, 1'b0, `FCPD_XFER_FORMAT})
        || (cmd_data == {2'b01, 1'b0, `FCPD_XFER_FORMAT});
    wire [1:0] sel = xfer_params_ff[1:0];
    fcpd_result_mux u_mux (
        .idx(ridx_ff),
        .bytes(rbytes_ff),
        .data(mux_out)
    );
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff <= S_IDLE;
            op_ff <= 8'h00;
            pcnt_ff <= 4'h0;
            need_ff <= 4'h0;
            ridx_ff <= 4'h0;
            rcnt_ff <= 4'h0;
            rbytes_ff <= 80'h0;
            eot_ff <= 8'h00;
            sc_ff <= 8'h00;
            last_fmt_ff <= 1'b0;
            res_data_ff <= 8'h00;
            res_valid_ff <= 1'b0;
            cmd_busy_ff <= 1'b0;
            drive_busy_ff <= 4'h0;
            seek_req_ff <= 1'b0;
            seek_cyl_ff <= 8'h00;
            seek_drive_ff <= 2'h0;
            id_req_ff <= 1'b0;
            xfer_req_ff <= 1'b0;
            xfer_kind_ff <= 5'h00;
            xfer_params_ff <= 64'h0;
            double_density_flag_ff <= 1'b0;
            head_select_ff <= 1'b0;
            write_gate_mode_ff <= 2'h0;
            perp_drive_ff <= 4'h0;
            lock_ff <= 1'b0;
            standby_ff <= 1'b0;
        end
        else
        begin
            seek_req_ff <= 1'b0;
            id_req_ff <= 1'b0;
            xfer_req_ff <= 1'b0;
            case (state_ff)
            S_IDLE:
                if (cmd_wr)
                begin
                    op_ff <= cmd_data;
                    pcnt_ff <= 4'h0;
                    cmd_busy_ff <= 1'b1;
                    standby_ff <= 1'b0;
                    ridx_ff <= 4'h0;
                    if (cmd_data == `FCPD_OP_DUMP)
                    begin
                        rbytes_ff <= {precomp_start_track,
                            1'b0, implied_seek_enable, fifo_disable_flag,
                            poll_disable, fifo_threshold,
                            lock_ff, 1'b0, perp_drive_ff, write_gate_mode_ff,
                            last_fmt_ff ? sc_ff : eot_ff,
                            head_load_time, non_dma_flag,
                            step_rate_time, head_unload_time,
                            present_cylinder_number};
                        rcnt_ff <= `FCPD_DUMP_RESULTS;
                        state_ff <= S_RES;
                    end
                    else if ((cmd_data & `FCPD_OP_LOCK_MASK) == `FCPD_OP_LOCK)
                    begin
                        lock_ff <= cmd_data[7];
                        rbytes_ff <= {72'h0, 3'b000, cmd_data[7], 4'h0};
                        rcnt_ff <= 4'h1;
                        state_ff <= S_RES;
                    end
                    else if (cmd_data == `FCPD_OP_PERP)
                    begin
                        need_ff <= 4'h1;
                        state_ff <= S_PARM;
                    end
                    else if ((cmd_data & `FCPD_OP_RDID_MASK) == `FCPD_OP_RDID)
                    begin
                        double_density_flag_ff <= cmd_data[6];
                        need_ff <= 4'h1;
                        state_ff <= S_PARM;
                    end
                    else if (is_xfer || is_fmt)
                    begin
                        xfer_kind_ff <= low;
                        double_density_flag_ff <= cmd_data[6];
                        need_ff <= is_fmt ? 4'h5 : `FCPD_XFER_PARAMS;
                        state_ff <= S_PARM;
                    end
                    else
                    begin
                        rbytes_ff <= {72'h0, `FCPD_ST0_INVALID};
                        rcnt_ff <= 4'h1;
                        standby_ff <= 1'b1;
                        state_ff <= S_RES;
                    end
                end
            S_PARM:
                if (cmd_wr)
                begin
                    xfer_params_ff[pcnt_ff*8 +: 8] <= cmd_data;
                    pcnt_ff <= pcnt_ff + 4'h1;
                    if (pcnt_ff + 4'h1 == need_ff)
                    begin
                        if (op_ff == `FCPD_OP_PERP)
                        begin
                            write_gate_mode_ff <= cmd_data[1:0];
                            if (cmd_data[7])
                                perp_drive_ff <= cmd_data[5:2];
                            cmd_busy_ff <= 1'b0;
                            state_ff <= S_IDLE;
                        end
                        else if ((op_ff & `FCPD_OP_RDID_MASK) == `FCPD_OP_RDID)
                        begin
                            head_select_ff <= cmd_data[2];
                            seek_drive_ff <= cmd_data[1:0];
                            id_req_ff <= 1'b1;
                            state_ff <= S_RDID;
                        end
                        else
                        begin
                            last_fmt_ff <= (op_ff[4:0] == `FCPD_XFER_FORMAT);
                            if (op_ff[4:0] == `FCPD_XFER_FORMAT)
                                sc_ff <= xfer_params_ff[23:16];
                            else
                                eot_ff <= xfer_params_ff[47:40];
                            head_select_ff <= xfer_params_ff[2];
                            seek_drive_ff <= xfer_params_ff[1:0];
                            seek_cyl_ff <= xfer_params_ff[15:8];
                            if (implied_seek_enable &&
                                op_ff[4:0] != `FCPD_XFER_FORMAT)
                            begin
                                seek_req_ff <= 1'b1;
                                drive_busy_ff[xfer_params_ff[1:0]] <= 1'b1;
                                state_ff <= S_SEEK;
                            end
                            else
                            begin
                                xfer_req_ff <= 1'b1;
                                state_ff <= S_EXEC;
                            end
                        end
                    end
                end
            S_SEEK:
                if (seek_fail)
                begin
                    drive_busy_ff[sel] <= 1'b0;
                    rbytes_ff <= {24'h0, xfer_params_ff[39:32],
                        xfer_params_ff[31:16], seek_fail_cyl,
                        op_status[23:8], seek_fail_st0};
                    rcnt_ff <= `FCPD_XFER_RESULTS;
                    state_ff <= S_RES;
                end
                else if (seek_done)
                begin
                    drive_busy_ff[sel] <= 1'b0;
                    xfer_req_ff <= 1'b1;
                    state_ff <= S_EXEC;
                end
            S_EXEC:
                if (op_done)
                begin
                    rbytes_ff <= {24'h0, id_field, op_status};
                    rcnt_ff <= `FCPD_XFER_RESULTS;
                    state_ff <= S_RES;
                end
            S_RDID:
                if (id_found || op_done)
                begin
                    rbytes_ff <= {24'h0, id_field, op_status};
                    rcnt_ff <= `FCPD_XFER_RESULTS;
                    state_ff <= S_RES;
                end
            S_RES:
            begin
                res_valid_ff <= 1'b1;
                res_data_ff <= mux_out;
                if (res_rd && res_valid_ff)
                begin
                    res_valid_ff <= 1'b0;
                    ridx_ff <= ridx_ff + 4'h1;
                    if (ridx_ff + 4'h1 == rcnt_ff)
                    begin
                        cmd_busy_ff <= 1'b0;
                        state_ff <= S_IDLE;
                    end
                end
            end
            default:
                state_ff <= S_IDLE;
            endcase
        end
    end
endmodule // fcpd_decoder

// ===== fcpd_decoder_sva.sv
// Port checks for the command phase decoder
`timescale 1ns/100ps
module fcpd_decoder_chk (
    input wire clk,
    input wire rst_n,
    input wire cmd_wr,
    input wire [7:0] cmd_data,
    input wire res_rd,
    input wire [31:0] present_cylinder_number,
    input wire seek_fail,
    input wire [7:0] seek_fail_st0,
    input wire [7:0] res_data_ff,
    input wire res_valid_ff,
    input wire cmd_busy_ff,
    input wire [3:0] drive_busy_ff,
    input wire seek_req_ff,
    input wire [1:0] seek_drive_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Only a write while idle is an opcode
    wire op_wr = cmd_wr && !cmd_busy_ff;
    chk_lock_answer: assert property (
        op_wr && cmd_data[6:0] == 7'h14 |-> ##2 res_valid_ff &&
        res_data_ff == (($past(cmd_data, 2) >> 3) & 8'h10)
    ) else $error("lock answer wrong");
    chk_invalid_answer: assert property (
        op_wr && cmd_data == 8'h00 |-> ##2 res_valid_ff && res_data_ff == 8'h80
    ) else $error("invalid code answer wrong");
    chk_dump_first: assert property (
        op_wr && cmd_data == 8'h0E |-> ##2 res_valid_ff &&
        res_data_ff == $past(present_cylinder_number[7:0], 2)
    ) else $error("dump first byte wrong");
    chk_perp_silent: assert property (
        op_wr && cmd_data == 8'h12 |=> !res_valid_ff [*8]
    ) else $error("perpendicular gave a result");
    chk_seek_busy: assert property (
        seek_req_ff |-> ##1 drive_busy_ff[seek_drive_ff]
    ) else $error("drive busy missing in seek");
    chk_fail_status: assert property (
        seek_fail && cmd_busy_ff |-> ##2 res_valid_ff &&
        res_data_ff == $past(seek_fail_st0, 2)
    ) else $error("seek fail status wrong");
    chk_result_holds: assert property (
        res_valid_ff && !res_rd |=> res_valid_ff && $stable(res_data_ff)
    ) else $error("result byte did not stand");
    chk_result_drop: assert property (
        res_valid_ff && res_rd |=> !res_valid_ff
    ) else $error("result valid did not drop");
endmodule // fcpd_decoder_chk
bind fcpd_decoder fcpd_decoder_chk u_chk (.*);

// ===== fcpd_drive_model.sv
// Drive-side engines: seek, identifier search, execution
`timescale 1ns/100ps
module fcpd_drive_model #(parameter [2:0] LAT = 3'h3) (
    input wire clk,
    input wire fail_en,
    input wire seek_req_ff,
    input wire id_req_ff,
    input wire xfer_req_ff,
    output reg seek_done = 1'h0,
    output reg seek_fail = 1'h0,
    output reg id_found = 1'h0,
    output reg op_done = 1'h0,
    output wire [7:0] seek_fail_st0,
    output wire [7:0] seek_fail_cyl,
    output wire [31:0] id_field,
    output wire [23:0] op_status
);
    reg [2:0] sk_cnt = 3'h0;
    reg [2:0] id_cnt = 3'h0;
    reg [2:0] ex_cnt = 3'h0;
    // Status held fixed: cheaper, but hides stale-capture faults
    assign seek_fail_st0 = 8'h41;
    assign seek_fail_cyl = 8'h27;
    assign id_field = 32'h02090105;
    assign op_status = 24'h040120;
    always @(negedge clk)
    begin
        seek_done <= sk_cnt == 3'h1 && !fail_en;
        seek_fail <= sk_cnt == 3'h1 && fail_en;
        id_found <= id_cnt == 3'h1;
        op_done <= ex_cnt == 3'h1;
        sk_cnt <= seek_req_ff ? LAT : sk_cnt - (sk_cnt != 3'h0);
        id_cnt <= id_req_ff ? LAT : id_cnt - (id_cnt != 3'h0);
        ex_cnt <= xfer_req_ff ? LAT : ex_cnt - (ex_cnt != 3'h0);
    end
endmodule // fcpd_drive_model

// ===== floppy_command_phase_decoder_test.sv
// Bench for the floppy command phase decoder
`timescale 1ns/100ps
module floppy_command_phase_decoder_test;
    reg clk = 1'h0;
    reg rst_n = 1'h0;
    reg cmd_wr = 1'h0;
    reg res_rd = 1'h0;
    reg fail_en = 1'h1;
    reg non_dma_flag = 1'h1;
    reg implied_seek_enable = 1'h0;
    reg fifo_disable_flag = 1'h1;
    reg poll_disable = 1'h0;
    reg [7:0] cmd_data = 8'h00;
    reg [31:0] present_cylinder_number = 32'h44332211;
    reg [3:0] step_rate_time = 4'hA;
    reg [3:0] head_unload_time = 4'h5;
    reg [6:0] head_load_time = 7'h2B;
    reg [3:0] fifo_threshold = 4'h7;
    reg [7:0] precomp_start_track = 8'h3C;
    reg [24:0] kinds = {5'h06, 5'h0C, 5'h05, 5'h09, 5'h16};
    reg [79:0] x;
    wire seek_done, seek_fail, id_found, op_done, lock_ff, standby_ff;
    wire res_valid_ff, cmd_busy_ff, seek_req_ff, id_req_ff, xfer_req_ff;
    wire [7:0] seek_fail_st0, seek_fail_cyl, res_data_ff, seek_cyl_ff;
    wire [31:0] id_field;
    wire [23:0] op_status;
    wire [3:0] drive_busy_ff, perp_drive_ff;
    wire [1:0] write_gate_mode_ff, seek_drive_ff;
    wire [4:0] xfer_kind_ff;
    wire [63:0] xfer_params_ff;
    wire double_density_flag_ff, head_select_ff;
    integer fails = 0, checks = 0, cyc = 0, w, i, k;
    fcpd_decoder u_dut (.*);
    fcpd_drive_model u_drive (.*);
    always #50 clk = ~clk;
    task test_done;
    begin
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            fails = fails + 1;
            test_done;
        end
    end
    task ck(input string n, input [7:0] e, input [7:0] g);
    begin
        checks = checks + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    end
    endtask
    // Strobe drops for a cycle so no signal is set twice in one step
    task wr(input [7:0] b);
    begin
        cmd_data = b;
        cmd_wr = 1'h1;
        @(negedge clk);
        cmd_wr = 1'h0;
        @(negedge clk);
    end
    endtask
    task op(input [7:0] b);
    begin
        for (w = 0; w < 200 && cmd_busy_ff !== 1'h0; w = w + 1)
            @(negedge clk);
        wr(b);
    end
    endtask
    task rd(input [7:0] e, input c);
    begin
        for (w = 0; w < 200 && res_valid_ff !== 1'h1; w = w + 1)
            @(negedge clk);
        if (c)
            ck("res_data_ff", e, res_data_ff);
        res_rd = 1'h1;
        @(negedge clk);
        res_rd = 1'h0;
    end
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        op(8'h94);
        rd(8'h10, 1'h1);
        ck("lock_ff", 8'h01, lock_ff);
        op(8'h12);
        wr(8'hBE);
        repeat (10) @(negedge clk);
        ck("perp_drive_ff", 8'h0F, perp_drive_ff);
        ck("write_gate_mode_ff", 8'h02, write_gate_mode_ff);
        ck("seek_drive_ff", 8'h00, seek_drive_ff);
        ck("res_valid_ff", 8'h00, res_valid_ff);
        op(8'h00);
        rd(8'h80, 1'h1);
        ck("standby_ff", 8'h01, standby_ff);
        $display("lock, perpendicular, invalid test done");
        op(8'h4A);
        wr(8'h05);
        ck("head_select_ff", 8'h01, head_select_ff);
        ck("double_density_flag_ff", 8'h01, double_density_flag_ff);
        ck("seek_drive_ff", 8'h01, seek_drive_ff);
        x = 56'h20010405010902;
        for (i = 6; i >= 0; i = i - 1)
            rd(x[8 * i +: 8], 1'h1);
        $display("read identifier test done");
        implied_seek_enable = 1'h1;
        for (k = 0; k < 5; k = k + 1)
        begin
            op({3'h2, kinds[5 * k +: 5]});
            x = 64'hFF1B120201000501;
            for (i = 0; i < 8; i = i + 1)
                wr(x[8 * i +: 8]);
            // Seek is still running here, so the busy bit must stand
            ck("drive_busy_ff", 8'h02, drive_busy_ff);
            ck("xfer_kind_ff", {3'h0, kinds[5 * k +: 5]}, xfer_kind_ff);
            ck("xfer_params_ff", 8'h05, xfer_params_ff[15:8]);
            ck("seek_cyl_ff", 8'h05, seek_cyl_ff);
            x = 56'h41000027000102;
            for (i = 6; i >= 0; i = i - 1)
                rd(x[8 * i +: 8], i != 5 && i != 4);
        end
        fail_en = 1'h0;
        op(8'h46);
        x = 64'hFF1B120201000501;
        for (i = 0; i < 8; i = i + 1)
            wr(x[8 * i +: 8]);
        ck("drive_busy_ff", 8'h02, drive_busy_ff);
        x = 56'h20010405010902;
        for (i = 6; i >= 0; i = i - 1)
            rd(x[8 * i +: 8], 1'h1);
        ck("drive_busy_ff", 8'h00, drive_busy_ff);
        $display("transfer test done");
        op(8'h0E);
        x = 80'h11223344A55712BE673C;
        for (i = 9; i >= 0; i = i - 1)
            rd(x[8 * i +: 8], 1'h1);
        // Format skips the implied seek and leaves its sector count
        op(8'h4D);
        x = 40'hF61B090201;
        for (i = 0; i < 5; i = i + 1)
            wr(x[8 * i +: 8]);
        ck("drive_busy_ff", 8'h00, drive_busy_ff);
        rd(8'h20, 1'h1);
        for (i = 0; i < 6; i = i + 1)
            rd(8'h00, 1'h0);
        op(8'h0E);
        for (i = 0; i < 10; i = i + 1)
            rd(8'h09, i == 6);
        $display("register dump test done");
        test_done;
    end
endmodule // floppy_command_phase_decoder_test
